/* verif/evc_partner.sv */
// evc_partner: stands in for the acquisition, exposure, trigger and timer logic and the lines
// assumes the bench asks for events and line levels just after a rising mclk edge
`default_nettype none
module evc_partner
  import evc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [8:0] ev_req,
  input wire logic [2:0] line_req,
  output var evc_events_t events,
  output logic [2:0] input_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered so each request leaves as a clean one-cycle pulse aligned to mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= evc_events_t'(ev_req);
    end
  end
  // the lines are plain levels; the counter must synchronise them itself
  assign input_lines = line_req;
endmodule : evc_partner
`default_nettype wire

/* verif/test_event_counter_source_control.sv */
// test_event_counter_source_control: self-checking bench for the event counter
// assumes evc_counter answers Wishbone with one wait and evc_partner drives events and lines
`default_nettype none
`include "evc_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module test_event_counter_source_control
  import evc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, cyc, stb, we, ack, done;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, seed, m_cfg;
  logic [2:0] state, lines, lines_req;
  logic [8:0] ev_req;
  evc_events_t events;
  int n_mismatch, checks_done, done_cnt, m_val, n, j, e;
  int inc_src[$] = '{1, 2, 3, 4, 5, 6, 7, 12};
  int inc_bit[$] = '{8, 7, 6, 5, 4, 3, 2, 0};
  int clr_src[$] = '{1, 2, 3, 4, 5, 5, 6, 7};
  int clr_bit[$] = '{8, 7, 6, 5, 3, 1, 3, 1};
  int clr_miss[$] = '{2, 2, 2, 2, 2, 2, 1, 3};
  int beg_src[$] = '{1, 2, 3, 4, 5, 6, 7, 11};
  int beg_bit[$] = '{8, 7, 6, 5, 2, 4, 3, 0};

  evc_counter evc_counter_i (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .events(events), .input_lines(lines), .counter_one_done(done),
    .count_state(state));
  evc_partner evc_partner_i (.mclk(mclk), .rst(rst), .ev_req(ev_req), .line_req(lines_req),
    .events(events), .input_lines(lines));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) if (done === 1'b1) done_cnt++;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // classic single cycle: request held until ack is sampled, released after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("FAIL t=%0t bus gave no ack", $time);
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(q, x)
  endtask : rd

  task automatic pulse(input int b);
    ev_req <= 9'h001 << b;
    @(posedge mclk);
    ev_req <= 9'h000;
    repeat (3) @(posedge mclk);
  endtask : pulse

  // six edges cover the synchroniser and edge stage
  task automatic line(input int i, input logic v);
    lines_req[i] <= v;
    repeat (6) @(posedge mclk);
  endtask : line

  // a wrong-direction edge first where one exists, then the edge that should act
  task automatic fire_edge(input int i, input int ed, input logic [7:0] a, input logic [31:0] x);
    if (ed != 2) line(i, ed[0]);
    rd(a, x);
    line(i, ~lines_req[i]);
  endtask : fire_edge

  // mode off, configure, mode on, then a command clear so the model starts from zero
  task automatic setup(input logic [3:0] bg, input logic [1:0] be, input logic [3:0] ic,
      input logic [1:0] ie, input logic [3:0] cl, input logic [1:0] ce, input logic [31:0] dur);
    m_cfg = {10'h000, ce, cl, 2'b00, ie, ic, 2'b00, be, bg};
    bus(1'b1, `EVC_ADR_MODE, 32'h0000_0000);
    bus(1'b1, `EVC_ADR_CFG, m_cfg);
    bus(1'b1, `EVC_ADR_DUR, dur);
    bus(1'b1, `EVC_ADR_MODE, 32'h0000_0001);
    bus(1'b1, `EVC_ADR_CMD, 32'h0000_0001);
    m_val = 0;
  endtask : setup

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    ev_req = 9'h000;
    lines_req = 3'h0;
    seed = 32'h0000_b0bb;
    n_mismatch = 0;
    checks_done = 0;
    done_cnt = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`EVC_ADR_DUR, 32'h0000_0001);
    rd(`EVC_ADR_CFG, 32'h0000_0000);
    rd(`EVC_ADR_STAT, 32'h0000_0000);
    rd(`EVC_ADR_VAL, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    for (j = 0; j < 8; j++) begin
      e = j % 3;
      setup(4'(8 + (j + 1) % 3), e[1:0], inc_src[j][3:0], 2'b00, 4'h0, 2'b00, 32'h0000_0100);
      pulse(inc_bit[j]);
      rd(`EVC_ADR_VAL, 32'h0000_0000);
      fire_edge((j + 1) % 3, e, `EVC_ADR_STAT, 32'h0000_0001);
      `CHK(state, ST_COUNTING)
      n = 1 + rnd() % 5;
      repeat (n) pulse(inc_bit[j]);
      pulse(inc_bit[(j + 1) % 8]);
      rd(`EVC_ADR_VAL, n);
      bus(1'b1, `EVC_ADR_CFG, 32'h0000_0000);
      rd(`EVC_ADR_CFG, m_cfg);
      bus(1'b1, `EVC_ADR_CMD, 32'h0000_0001);
      rd(`EVC_ADR_VAL, 32'h0000_0000);
      rd(`EVC_ADR_VRST, n);
      rd(`EVC_ADR_STAT, 32'h0000_0001);
    end
    setup(4'h1, 2'b01, 4'h0, 2'b00, 4'h0, 2'b00, 32'h0000_0100);
    pulse(8);
    rd(`EVC_ADR_STAT, 32'h0000_0002);
    for (j = 0; j < 8; j++) pulse(inc_bit[j]);
    rd(`EVC_ADR_VAL, 32'h0000_0000);
    // every event start source but counter_one_done, with the edge bits set to none to show they are ignored
    for (j = 0; j < 8; j++) begin
      setup(beg_src[j][3:0], 2'b11, 4'h0, 2'b00, 4'h0, 2'b00, 32'h0000_0100);
      pulse(beg_bit[(j + 1) % 8]);
      rd(`EVC_ADR_STAT, 32'h0000_0001);
      pulse(beg_bit[j]);
      rd(`EVC_ADR_STAT, 32'h0000_0002);
    end
    setup(4'h0, 2'b00, 4'h0, 2'b00, 4'h0, 2'b00, 32'h0000_0100);
    pulse(8);
    rd(`EVC_ADR_STAT, 32'h0000_0000);
    setup(4'hc, 2'b00, 4'hc, 2'b00, 4'h0, 2'b00, 32'h0000_0100);
    pulse(0);
    rd(`EVC_ADR_STAT, 32'h0000_0001);
    setup(4'h8, 2'b11, 4'h0, 2'b00, 4'h0, 2'b00, 32'h0000_0100);
    line(0, ~lines_req[0]);
    rd(`EVC_ADR_STAT, 32'h0000_0001);
    for (j = 0; j < 9; j++) begin
      e = j % 3;
      setup(4'h1, 2'b11, 4'(8 + j / 3), e[1:0], 4'h0, 2'b00, 32'h0000_0100);
      pulse(8);
      n = 2 + rnd() % 4;
      repeat (n) begin
        line(j / 3, ~lines_req[j / 3]);
        if (e == 2 || (e == 0) == lines_req[j / 3]) m_val++;
      end
      rd(`EVC_ADR_VAL, m_val);
    end
    for (j = 0; j < 8; j++) begin
      setup(4'h6, 2'b00, 4'hc, 2'b00, clr_src[j][3:0], 2'b00, 32'h0000_0100);
      pulse(4);
      n = 1 + rnd() % 4;
      repeat (n) pulse(0);
      pulse(clr_miss[j]);
      rd(`EVC_ADR_VAL, n);
      pulse(clr_bit[j]);
      rd(`EVC_ADR_VAL, 32'h0000_0000);
      rd(`EVC_ADR_VRST, n);
      pulse(0);
      rd(`EVC_ADR_VAL, 32'h0000_0000);
    end
    for (e = 0; e < 3; e++) begin
      setup(4'h6, 2'b00, 4'hc, 2'b00, 4'h8, e[1:0], 32'h0000_0100);
      pulse(4);
      pulse(0);
      fire_edge(0, e, `EVC_ADR_VAL, 32'h0000_0001);
      rd(`EVC_ADR_VAL, 32'h0000_0000);
    end
    setup(4'h6, 2'b00, 4'hc, 2'b00, 4'h0, 2'b00, 32'h0000_0003);
    pulse(4);
    done_cnt = 0;
    repeat (3) pulse(0);
    `CHK(done_cnt, 1)
    rd(`EVC_ADR_STAT, 32'h0000_0003);
    rd(`EVC_ADR_VAL, 32'h0000_0003);
    pulse(4);
    rd(`EVC_ADR_STAT, 32'h0000_0002);
    setup(4'h6, 2'b00, 4'hb, 2'b00, 4'h0, 2'b00, 32'h0000_1000);
    pulse(4);
    repeat (200) @(posedge mclk);
    bus(1'b0, `EVC_ADR_VAL, 32'h0000_0000);
    `CHK(q >= 32'h0000_0009 && q <= 32'h0000_000b, 1'b1)
    results();
  end
endmodule : test_event_counter_source_control
`default_nettype wire

/* verilog/evc_counter.sv */
// evc_counter: 32-bit event counter with start, increment and clear source selection
// assumes a classic Wishbone master, event pulses one mclk wide and synchronous to mclk
// Function
// - start source counter_one_done starts counting when the own end event fires
// - start edge selection applies only to line start sources
// - line start begins on rising, falling or either edge per start_edge_select
// - increment source selects the advancing event; off holds the counter still
// - advance by one on the selected acquisition, exposure, frame or trigger event
// - line increment sources advance on matching transitions of the chosen line
// - microsecond tick increment advances once per microsecond of mclk
// - timer increment source advances once per timer_one_done
// - increment_edge_select picks rising, falling or both edges of the line
// - clear event zeroes the counter, then it waits for the next start
// - command clear setting clears only on the software command
// - clear may follow acquisition or exposure begin and finish events
// - frame trigger clear setting clears on accepted and rejected triggers
// - separate clear settings for accepted-only and rejected-only frame triggers
// - input_line_one clear source clears on the selected transition
// - clear_edge_select picks rising, falling or either edge for line clear
// - terminal_count_setting sets increments before counter_one_done fires
// - count_state reports idle, waiting, counting, completed or overflowed
// - configuration writes only take effect while count_enable_mode is off
`default_nettype none
`include "evc_params.svh"
module evc_counter
  import evc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire evc_events_t events,
  input wire logic [2:0] input_lines,
  output logic counter_one_done,
  output logic [2:0] count_state
);
  function automatic logic edge_hit(input logic [1:0] sel, input logic up, input logic dn);
    case (sel)
      EDGE_UP: edge_hit = up;
      EDGE_DOWN: edge_hit = dn;
      EDGE_EITHER: edge_hit = up | dn;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  logic ack_ff;
  logic [31:0] rdata_ff;
  logic mode_ff;
  logic [31:0] cfg_ff;
  logic [31:0] dur_ff;
  logic [31:0] value_ff;
  logic [31:0] vrst_ff;
  logic done_ff;
  logic [`EVC_TICK_W-1:0] div_ff;
  logic tick_ff;
  evc_state_t state_ff;
  evc_state_t nxt_state;
  logic [31:0] nxt_value;
  logic nxt_done;
  logic [2:0] line_rise;
  logic [2:0] line_fall;

  evc_line_edge u_line_edge (
    .mclk(mclk),
    .rst(rst),
    .lines(input_lines),
    .rise(line_rise),
    .fall(line_fall)
  );

  // bus decode: write lands on the edge at which the master samples ack
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_go = bus_req & wb_we_i & ack_ff;
  wire wr_mode = wr_go & (wb_adr_i == `EVC_ADR_MODE);
  wire wr_cfg = wr_go & (wb_adr_i == `EVC_ADR_CFG) & ~mode_ff;
  wire wr_dur = wr_go & (wb_adr_i == `EVC_ADR_DUR) & ~mode_ff;
  wire sw_clear = wr_go & (wb_adr_i == `EVC_ADR_CMD) & wb_sel_i[0] & wb_dat_i[0];

  wire [3:0] beg_sel = cfg_ff[`EVC_CFG_BEG_HI:`EVC_CFG_BEG_LO];
  wire [1:0] beg_edge = cfg_ff[`EVC_CFG_BEDGE_HI:`EVC_CFG_BEDGE_LO];
  wire [3:0] inc_sel = cfg_ff[`EVC_CFG_INC_HI:`EVC_CFG_INC_LO];
  wire [1:0] inc_edge = cfg_ff[`EVC_CFG_IEDGE_HI:`EVC_CFG_IEDGE_LO];
  wire [3:0] clr_sel = cfg_ff[`EVC_CFG_CLR_HI:`EVC_CFG_CLR_LO];
  wire [1:0] clr_edge = cfg_ff[`EVC_CFG_CEDGE_HI:`EVC_CFG_CEDGE_LO];

  wire [2:0] beg_line = {edge_hit(beg_edge, line_rise[2], line_fall[2]),
                         edge_hit(beg_edge, line_rise[1], line_fall[1]),
                         edge_hit(beg_edge, line_rise[0], line_fall[0])};
  wire [2:0] inc_line = {edge_hit(inc_edge, line_rise[2], line_fall[2]),
                         edge_hit(inc_edge, line_rise[1], line_fall[1]),
                         edge_hit(inc_edge, line_rise[0], line_fall[0])};
  wire clr_line = edge_hit(clr_edge, line_rise[0], line_fall[0]);

  // start: edge selection only matters for the line sources
  logic start_hit;
  always_comb begin
    case (beg_sel)
      BEG_ACQ_BEGIN: start_hit = events.acq_begin;
      BEG_ACQ_FINISH: start_hit = events.acq_finish;
      BEG_EXP_BEGIN: start_hit = events.exp_begin;
      BEG_EXP_FINISH: start_hit = events.exp_finish;
      BEG_REJ_TRIG: start_hit = events.rejected_trig;
      BEG_FRAME_BEGIN: start_hit = events.frame_begin;
      BEG_ACC_FRAME: start_hit = events.accepted_frame;
      BEG_LINE_ONE: start_hit = beg_line[0];
      BEG_LINE_TWO: start_hit = beg_line[1];
      BEG_LINE_THREE: start_hit = beg_line[2];
      BEG_TIMER_DONE: start_hit = events.timer_done;
      BEG_COUNTER_DONE: start_hit = done_ff;
      default: start_hit = 1'b0;
    endcase
  end

  logic inc_hit;
  always_comb begin
    case (inc_sel)
      INC_ACQ_BEGIN: inc_hit = events.acq_begin;
      INC_ACQ_FINISH: inc_hit = events.acq_finish;
      INC_EXP_BEGIN: inc_hit = events.exp_begin;
      INC_EXP_FINISH: inc_hit = events.exp_finish;
      INC_FRAME_BEGIN: inc_hit = events.frame_begin;
      INC_ACC_FRAME: inc_hit = events.accepted_frame;
      INC_REJ_TRIG: inc_hit = events.rejected_trig;
      INC_LINE_ONE: inc_hit = inc_line[0];
      INC_LINE_TWO: inc_hit = inc_line[1];
      INC_LINE_THREE: inc_hit = inc_line[2];
      INC_USEC_TICK: inc_hit = tick_ff;
      INC_TIMER_DONE: inc_hit = events.timer_done;
      default: inc_hit = 1'b0;
    endcase
  end

  // the command always clears; the other settings add one hardware source
  logic clr_src_hit;
  always_comb begin
    case (clr_sel)
      CLR_ACQ_BEGIN: clr_src_hit = events.acq_begin;
      CLR_ACQ_FINISH: clr_src_hit = events.acq_finish;
      CLR_EXP_BEGIN: clr_src_hit = events.exp_begin;
      CLR_EXP_FINISH: clr_src_hit = events.exp_finish;
      CLR_FRAME_TRIG: clr_src_hit = events.accepted_frame | events.rejected_frame;
      CLR_ACC_FRAME: clr_src_hit = events.accepted_frame;
      CLR_REJ_FRAME: clr_src_hit = events.rejected_frame;
      CLR_LINE_ONE: clr_src_hit = clr_line;
      default: clr_src_hit = 1'b0;
    endcase
  end
  wire clr_hit = sw_clear | (mode_ff & clr_src_hit);
  wire beg_off = (beg_sel == BEG_OFF);
  wire at_max = (value_ff == `EVC_MAX_COUNT);
  wire [31:0] value_inc = value_ff + 32'h0000_0001;

  always_comb begin
    nxt_state = state_ff;
    nxt_value = value_ff;
    nxt_done = 1'b0;
    if (!mode_ff || beg_off) begin
      nxt_state = ST_IDLE;
      if (clr_hit) begin
        nxt_value = 32'h0000_0000;
      end
    end else if (clr_hit) begin
      nxt_state = ST_WAIT;
      nxt_value = 32'h0000_0000;
    end else begin
      case (state_ff)
        ST_IDLE: nxt_state = ST_WAIT;
        ST_WAIT: begin
          if (start_hit) begin
            nxt_state = ST_COUNTING;
          end
        end
        ST_COUNTING: begin
          if (inc_hit && at_max) begin
            nxt_state = ST_OVERFLOW;
          end else if (inc_hit) begin
            nxt_value = value_inc;
            if (value_inc == dur_ff) begin
              nxt_state = ST_DONE;
              nxt_done = 1'b1;
            end
          end
        end
        // completed counter rearms on its start source from zero
        ST_DONE: begin
          if (start_hit) begin
            nxt_state = ST_COUNTING;
            nxt_value = 32'h0000_0000;
          end
        end
        ST_OVERFLOW: nxt_state = ST_OVERFLOW;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      value_ff <= 32'h0000_0000;
      vrst_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      value_ff <= nxt_value;
      done_ff <= nxt_done;
      if (clr_hit) begin
        vrst_ff <= value_ff;
      end
    end
  end

  // microsecond tick from mclk
  wire tick_wrap = (div_ff == `EVC_TICK_W'(`EVC_TICK_CYCLES - 1));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= tick_wrap ? '0 : div_ff + `EVC_TICK_W'(1);
      tick_ff <= tick_wrap;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_ff <= 1'b0;
      cfg_ff <= `EVC_CFG_RST;
      dur_ff <= `EVC_DUR_RST;
    end else begin
      if (wr_mode && wb_sel_i[0]) begin
        mode_ff <= wb_dat_i[0];
      end
      if (wr_cfg) begin
        cfg_ff <= merge(cfg_ff, wb_dat_i, wb_sel_i);
      end
      if (wr_dur) begin
        dur_ff <= merge(dur_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // read mux; unmapped offsets answer with zero
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      `EVC_ADR_MODE: rd_mux = {31'h0000_0000, mode_ff};
      `EVC_ADR_CFG: rd_mux = cfg_ff;
      `EVC_ADR_DUR: rd_mux = dur_ff;
      `EVC_ADR_STAT: rd_mux = {29'h0000_0000, state_ff};
      `EVC_ADR_VAL: rd_mux = value_ff;
      `EVC_ADR_VRST: rd_mux = vrst_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      rdata_ff <= rd_mux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign counter_one_done = done_ff;
  assign count_state = state_ff;

  ack_single_a: assert property (@(posedge mclk) disable iff (rst)
    ack_ff |=> !ack_ff) else $error("ack held longer than one cycle");
  cfg_lock_a: assert property (@(posedge mclk) disable iff (rst)
    mode_ff |=> $stable(cfg_ff) && $stable(dur_ff)) else $error("config changed while active");
  inc_off_a: assert property (@(posedge mclk) disable iff (rst)
    (inc_sel == INC_OFF) && !clr_hit && !(state_ff == ST_DONE) |=> $stable(value_ff))
    else $error("counter moved with increment off");
  clear_wait_a: assert property (@(posedge mclk) disable iff (rst)
    clr_hit && mode_ff && !beg_off |=> (value_ff == 32'h0000_0000) && (state_ff == ST_WAIT))
    else $error("clear did not zero and rearm");
  start_go_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_WAIT) && start_hit && !clr_hit && mode_ff && !beg_off
    |=> state_ff == ST_COUNTING) else $error("start event missed");
  inc_step_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_COUNTING) && inc_hit && !at_max && !clr_hit && mode_ff && !beg_off
    |=> value_ff == $past(value_ff) + 32'h0000_0001) else $error("increment not by one");
  ovf_enter_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_COUNTING) && inc_hit && at_max && !clr_hit && mode_ff && !beg_off
    |=> state_ff == ST_OVERFLOW) else $error("overflow not entered");
  done_count_a: assert property (@(posedge mclk) disable iff (rst)
    done_ff |-> (value_ff == dur_ff) && (state_ff == ST_DONE))
    else $error("done without reaching terminal count");
  tick_rate_a: assert property (@(posedge mclk) disable iff (rst)
    tick_ff |=> !tick_ff [*8]) else $error("microsecond tick too frequent");
  idle_off_a: assert property (@(posedge mclk) disable iff (rst)
    !mode_ff |=> state_ff == ST_IDLE) else $error("not idle while off");
  // the end event feeds the start decode, so a stretched pulse would restart twice
  done_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    done_ff |=> !done_ff) else $error("end event longer than one cycle");
  // overflow sticks; only a clear, mode off or start source off leaves it
  ovf_stick_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_OVERFLOW) && !clr_hit && mode_ff && !beg_off
    |=> (state_ff == ST_OVERFLOW) && $stable(value_ff))
    else $error("overflow did not hold");
  wait_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_WAIT) && !start_hit && !clr_hit && mode_ff && !beg_off
    |=> (state_ff == ST_WAIT) && $stable(value_ff))
    else $error("counted before start");
  beg_off_idle_a: assert property (@(posedge mclk) disable iff (rst)
    beg_off |=> state_ff == ST_IDLE) else $error("not idle with start source off");
  off_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !mode_ff && !sw_clear |=> $stable(value_ff)) else $error("value moved while off");
  cmd_only_a: assert property (@(posedge mclk) disable iff (rst)
    (clr_sel == CLR_CMD) && !sw_clear && (state_ff == ST_COUNTING) && !inc_hit && mode_ff
    && !beg_off |=> state_ff == ST_COUNTING) else $error("cleared without the command");
  line_once_a: assert property (@(posedge mclk) disable iff (rst)
    (line_rise != 3'b000) |=> (line_rise & $past(line_rise)) == 3'b000)
    else $error("one line edge gave two rises");
  self_rearm_a: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == ST_DONE) && done_ff && (beg_sel == BEG_COUNTER_DONE) && !clr_hit && mode_ff
    |=> state_ff == ST_COUNTING) else $error("own end event did not restart");
endmodule : evc_counter
`default_nettype wire

/* verilog/evc_line_edge.sv */
// evc_line_edge: synchronises the three input lines and flags their edges
// assumes lines may change at any time relative to mclk
`default_nettype none
module evc_line_edge (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] lines,
  output logic [2:0] rise,
  output logic [2:0] fall
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] last_ff;
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_line
      // meta_ff feeds sync_ff only; edges come from the later stages
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
          last_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= lines[i];
          sync_ff[i] <= meta_ff[i];
          last_ff[i] <= sync_ff[i];
        end
      end
      assign rise[i] = sync_ff[i] & ~last_ff[i];
      assign fall[i] = ~sync_ff[i] & last_ff[i];
    end
  endgenerate
endmodule : evc_line_edge
`default_nettype wire

/* verilog/evc_params.svh */
// evc_params.svh: offsets, field positions, reset values and timing for the event counter
// assumes a 32-bit classic Wishbone register bus and a 20 MHz system clock
`ifndef EVC_PARAMS_SVH
`define EVC_PARAMS_SVH
`define EVC_ADR_MODE 8'h00
`define EVC_ADR_CFG 8'h04
`define EVC_ADR_DUR 8'h08
`define EVC_ADR_CMD 8'h0C
`define EVC_ADR_STAT 8'h10
`define EVC_ADR_VAL 8'h14
`define EVC_ADR_VRST 8'h18
`define EVC_CFG_BEG_LO 0
`define EVC_CFG_BEG_HI 3
`define EVC_CFG_BEDGE_LO 4
`define EVC_CFG_BEDGE_HI 5
`define EVC_CFG_INC_LO 8
`define EVC_CFG_INC_HI 11
`define EVC_CFG_IEDGE_LO 12
`define EVC_CFG_IEDGE_HI 13
`define EVC_CFG_CLR_LO 16
`define EVC_CFG_CLR_HI 19
`define EVC_CFG_CEDGE_LO 20
`define EVC_CFG_CEDGE_HI 21
`define EVC_CFG_RST 32'h0000_0000
`define EVC_DUR_RST 32'h0000_0001
`define EVC_MAX_COUNT 32'hFFFF_FFFF
`define EVC_CLK_PERIOD_NS 50
`define EVC_TICK_NS 1000
`define EVC_TICK_CYCLES (`EVC_TICK_NS / `EVC_CLK_PERIOD_NS)
`define EVC_TICK_W 5
`endif

/* verilog/evc_pkg.sv */
// evc_pkg: types shared by the event counter modules
// assumes evc_params.svh is compiled alongside
`default_nettype none
package evc_pkg;
  typedef enum logic [3:0] {
    BEG_OFF, BEG_ACQ_BEGIN, BEG_ACQ_FINISH, BEG_EXP_BEGIN, BEG_EXP_FINISH, BEG_REJ_TRIG,
    BEG_FRAME_BEGIN, BEG_ACC_FRAME, BEG_LINE_ONE, BEG_LINE_TWO, BEG_LINE_THREE,
    BEG_TIMER_DONE, BEG_COUNTER_DONE
  } evc_begin_src_t;
  typedef enum logic [3:0] {
    INC_OFF, INC_ACQ_BEGIN, INC_ACQ_FINISH, INC_EXP_BEGIN, INC_EXP_FINISH, INC_FRAME_BEGIN,
    INC_ACC_FRAME, INC_REJ_TRIG, INC_LINE_ONE, INC_LINE_TWO, INC_LINE_THREE,
    INC_USEC_TICK, INC_TIMER_DONE
  } evc_inc_src_t;
  typedef enum logic [3:0] {
    CLR_CMD, CLR_ACQ_BEGIN, CLR_ACQ_FINISH, CLR_EXP_BEGIN, CLR_EXP_FINISH, CLR_FRAME_TRIG,
    CLR_ACC_FRAME, CLR_REJ_FRAME, CLR_LINE_ONE
  } evc_clr_src_t;
  typedef enum logic [1:0] {EDGE_UP, EDGE_DOWN, EDGE_EITHER} evc_edge_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_COUNTING, ST_DONE, ST_OVERFLOW
  } evc_state_t;
  // one-cycle event pulses from the acquisition, exposure, trigger and timer logic
  typedef struct packed {
    logic acq_begin;
    logic acq_finish;
    logic exp_begin;
    logic exp_finish;
    logic frame_begin;
    logic accepted_frame;
    logic rejected_trig;
    logic rejected_frame;
    logic timer_done;
  } evc_events_t;
endpackage : evc_pkg
`default_nettype wire
